// ### serial_mode1_baud_gen.v
/*
 * two ten-bit asynchronous serial ports with their baud sources: an 8-bit
 * auto-reload timer shared by both ports and a 16-bit reload timer that
 * port 0 alone may use.
 * assumes ref_clk is the core clock; control bits arrive as plain levels
 * from software-held registers outside; serial lines are asynchronous pins.
 */
`timescale 1ns/1ns
`default_nettype none
`include "serial_mode1_regs.vh"

module serial_mode1_baud_gen (
    input  wire       ref_clk,
    input  wire       rst_n,
    input  wire [7:0] power_control_reg,
    input  wire [7:0] ext_interrupt_control_reg,
    input  wire       timer8_run,
    input  wire [7:0] timer8_reload_byte,
    input  wire       timer16_run,
    input  wire [7:0] timer16_reload_high,
    input  wire [7:0] timer16_reload_low,
    input  wire       tx_clock_from_timer16,
    input  wire       rx_clock_from_timer16,
    input  wire       timer16_clock_rate_sel,
    input  wire       timer16_ext_reload_enable,
    input  wire       timer16_ext_reload_trigger,
    input  wire       timer16_overflow_clear,
    output reg        timer16_overflow_flag,
    input  wire [7:0] tx_data_port0,
    input  wire       tx_start_port0,
    output wire       tx_busy_port0,
    output wire       txd_port0,
    input  wire       rxd_port0,
    output wire [7:0] rx_data_port0,
    output wire       rx_valid_port0,
    output wire       rx_stop_bit_port0,
    input  wire [7:0] tx_data_port1,
    input  wire       tx_start_port1,
    output wire       tx_busy_port1,
    output wire       txd_port1,
    input  wire       rxd_port1,
    output wire [7:0] rx_data_port1,
    output wire       rx_valid_port1,
    output wire       rx_stop_bit_port1
);
    reg  [3:0]  prescale_r;
    reg  [7:0]  timer8_r;
    reg  [15:0] timer16_r;
    reg         half_port0_r;
    reg         half_port1_r;
    reg  [2:0]  pin_s1_r;
    reg  [2:0]  pin_s2_r;
    reg  [2:0]  pin_s3_r;
    reg  [2:0]  pin_filt_r;
    reg         trig_prev_r;
    wire [2:0]  pins;
    wire        rx_in_port0;
    wire        rx_in_port1;
    wire        trig_level;
    wire        tick_div12;
    wire        tick_div4;
    wire        tick_div2;
    wire        serial_mode16;
    wire        timer16_tick;
    wire        timer8_ovf;
    wire        timer16_ovf;
    wire        trig_fall;
    wire        dbl_port0;
    wire        dbl_port1;
    wire        t8_baud_port0;
    wire        t8_baud_port1;
    wire        tx_tick_port0;
    wire        rx_tick_port0;

    assign pins        = {timer16_ext_reload_trigger, rxd_port1, rxd_port0};
    assign rx_in_port0 = pin_filt_r[0];
    assign rx_in_port1 = pin_filt_r[1];
    assign trig_level  = pin_filt_r[2];

    // three-stage pin synchroniser; a level is taken once stages two and
    // three agree, so a single-cycle disagreement never reaches the logic
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            pin_s1_r   <= 3'h7;
            pin_s2_r   <= 3'h7;
            pin_s3_r   <= 3'h7;
            pin_filt_r <= 3'h7;
        end else begin
            pin_s1_r   <= pins;
            pin_s2_r   <= pin_s1_r;
            pin_s3_r   <= pin_s2_r;
            pin_filt_r <= (pin_s2_r & pin_s3_r)
                        | (pin_filt_r & (pin_s2_r ^ pin_s3_r));
        end
    end

    // one modulo-12 prescaler yields the /12, /4 and /2 enables, since
    // 12 is a multiple of both 4 and 2
    always @(posedge ref_clk) begin
        if (!rst_n)
            prescale_r <= 4'h0;
        else if (prescale_r == `PRESCALE_LAST)
            prescale_r <= 4'h0;
        else
            prescale_r <= prescale_r + 4'h1;
    end

    assign tick_div12 = (prescale_r == `PRESCALE_LAST);
    assign tick_div4  = (prescale_r[1:0] == 2'h3);
    assign tick_div2  = prescale_r[0];

    // 16-bit timer rate: serial use forces core/2 over the rate select
    assign serial_mode16 = tx_clock_from_timer16 | rx_clock_from_timer16;
    assign timer16_tick  = serial_mode16 ? tick_div2 :
                           (timer16_clock_rate_sel ? tick_div4 : tick_div12);

    assign timer8_ovf  = timer8_run & tick_div12 & (timer8_r == `T8_MAX);
    assign timer16_ovf = timer16_run & timer16_tick
                       & (timer16_r == `T16_MAX);
    assign trig_fall   = trig_prev_r & ~trig_level;

    // 8-bit timer: counts core/12, reloads from the reload byte on rollover
    always @(posedge ref_clk) begin
        if (!rst_n)
            timer8_r <= 8'h00;
        else if (timer8_ovf)
            timer8_r <= timer8_reload_byte;
        else if (timer8_run && tick_div12)
            timer8_r <= timer8_r + 8'h01;
    end

    // 16-bit timer: reloads from the pair on rollover; the external
    // trigger reloads only while the timer is not a baud source
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            timer16_r   <= 16'h0000;
            trig_prev_r <= 1'b1;
        end else begin
            trig_prev_r <= trig_level;
            if (timer16_ovf)
                timer16_r <= {timer16_reload_high, timer16_reload_low};
            else if (trig_fall && timer16_ext_reload_enable
                     && !serial_mode16)
                timer16_r <= {timer16_reload_high, timer16_reload_low};
            else if (timer16_run && timer16_tick)
                timer16_r <= timer16_r + 16'h0001;
        end
    end

    // overflow flag: sticky, suppressed in baud use; a set beats a clear
    // arriving in the same cycle so no rollover is lost
    always @(posedge ref_clk) begin
        if (!rst_n)
            timer16_overflow_flag <= 1'b0;
        else if (timer16_ovf && !serial_mode16)
            timer16_overflow_flag <= 1'b1;
        else if (timer16_overflow_clear)
            timer16_overflow_flag <= 1'b0;
    end

    // per-port double-rate bits; without them rollovers are halved
    assign dbl_port0 = power_control_reg[`DBL_RATE_BIT];
    assign dbl_port1 = ext_interrupt_control_reg[`DBL_RATE_BIT];

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            half_port0_r <= 1'b0;
            half_port1_r <= 1'b0;
        end else if (timer8_ovf) begin
            half_port0_r <= ~half_port0_r;
            half_port1_r <= ~half_port1_r;
        end
    end

    assign t8_baud_port0 = timer8_ovf & (dbl_port0 | half_port0_r);
    assign t8_baud_port1 = timer8_ovf & (dbl_port1 | half_port1_r);

    // port 0 may pick the 16-bit timer per direction; port 1 cannot
    assign tx_tick_port0 = tx_clock_from_timer16 ? timer16_ovf
                                                 : t8_baud_port0;
    assign rx_tick_port0 = rx_clock_from_timer16 ? timer16_ovf
                                                 : t8_baud_port0;

    mode1_channel port0 (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .tx_tick     (tx_tick_port0),
        .rx_tick     (rx_tick_port0),
        .tx_data     (tx_data_port0),
        .tx_start    (tx_start_port0),
        .tx_busy     (tx_busy_port0),
        .txd         (txd_port0),
        .rx_in       (rx_in_port0),
        .rx_data     (rx_data_port0),
        .rx_valid    (rx_valid_port0),
        .rx_stop_bit (rx_stop_bit_port0)
    );

    mode1_channel port1 (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .tx_tick     (t8_baud_port1),
        .rx_tick     (t8_baud_port1),
        .tx_data     (tx_data_port1),
        .tx_start    (tx_start_port1),
        .tx_busy     (tx_busy_port1),
        .txd         (txd_port1),
        .rx_in       (rx_in_port1),
        .rx_data     (rx_data_port1),
        .rx_valid    (rx_valid_port1),
        .rx_stop_bit (rx_stop_bit_port1)
    );
endmodule
`default_nettype wire

// ### serial_mode1_regs.vh
/*
 * constants for the ten-bit asynchronous serial ports and their baud
 * timers: field positions, divider ratios, terminal counts and frame shape.
 * assumes it is included by bare name from the design files.
 */
// Contract
// - a frame is ten bits (start, eight data, stop) and both directions run at once.
// - the received stop bit is kept in that port's receive ninth-bit flag.
// - data bits go out and come in least significant bit first.
// - port 0 takes its baud from the 8-bit or the 16-bit timer, port 1 from the 8-bit timer only.
// - each 16-bit rollover, and each 8-bit rollover kept after any halving, gives one baud pulse, and sixteen of those make a bit.
// - on the 8-bit timer a per-port double-rate bit decides whether rollovers are halved first.
// - the double-rate bits are bit 7 of the power control and extended interrupt control bytes.
// - on the 8-bit timer the rate is 2^dbl/32 times core/(12*(256-reload byte)).
// - on the 16-bit timer the rate is core/(32*(65536-reload pair)).
// - a serial clock select on the 16-bit timer clocks it at core/2, overriding /4 or /12.
// - while a serial clock select is set, rollover does not set the overflow flag and the reload trigger is ignored.
`ifndef SERIAL_MODE1_REGS_VH
`define SERIAL_MODE1_REGS_VH

`define DBL_RATE_BIT     7
`define DATA_BITS        8
`define FRAME_BITS       10
`define OVERSAMPLE_LAST  4'hF
`define MID_SAMPLE       4'h7
`define LAST_DATA_INDEX  4'h7
`define LAST_FRAME_INDEX 4'h9
`define PRESCALE_LAST    4'hB
`define T8_MAX           8'hFF
`define T16_MAX          16'hFFFF

`endif

// ### mode1_channel.v
/*
 * one serial port in ten-bit frame mode: a transmitter and a receiver,
 * each paced by its own sixteen-times-bit-rate tick.
 * assumes the ticks are one-cycle pulses on ref_clk and rx_in is already
 * synchronised and filtered.
 */
`timescale 1ns/1ns
`default_nettype none
`include "serial_mode1_regs.vh"

module mode1_channel (
    input  wire       ref_clk,
    input  wire       rst_n,
    input  wire       tx_tick,
    input  wire       rx_tick,
    input  wire [7:0] tx_data,
    input  wire       tx_start,
    output wire       tx_busy,
    output reg        txd,
    input  wire       rx_in,
    output reg  [7:0] rx_data,
    output reg        rx_valid,
    output reg        rx_stop_bit
);
    localparam [3:0] RX_IDLE  = 4'h1;
    localparam [3:0] RX_START = 4'h2;
    localparam [3:0] RX_DATA  = 4'h4;
    localparam [3:0] RX_STOP  = 4'h8;

    reg [9:0] tx_shift_r;
    reg [3:0] tx_bit_r;
    reg [3:0] tx_sub_r;
    reg       tx_busy_r;
    reg [3:0] rx_state_r;
    reg [3:0] rx_sub_r;
    reg [3:0] rx_bit_r;
    reg [7:0] rx_shift_r;
    reg       rx_prev_r;

    assign tx_busy = tx_busy_r;

    // transmitter: frame loaded whole, shifted right so data leaves lsb first
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_shift_r <= 10'h3FF;
            tx_bit_r   <= 4'h0;
            tx_sub_r   <= 4'h0;
            tx_busy_r  <= 1'b0;
            txd        <= 1'b1;
        end else if (!tx_busy_r) begin
            txd <= 1'b1;
            if (tx_start) begin
                tx_shift_r <= {1'b1, tx_data, 1'b0};
                tx_bit_r   <= 4'h0;
                tx_sub_r   <= 4'h0;
                tx_busy_r  <= 1'b1;
                txd        <= 1'b0;
            end
        end else if (tx_tick) begin
            tx_sub_r <= tx_sub_r + 4'h1;
            if (tx_sub_r == `OVERSAMPLE_LAST) begin
                if (tx_bit_r == `LAST_FRAME_INDEX) begin
                    tx_busy_r <= 1'b0;
                    txd       <= 1'b1;
                end else begin
                    tx_shift_r <= {1'b1, tx_shift_r[9:1]};
                    txd        <= tx_shift_r[1];
                    tx_bit_r   <= tx_bit_r + 4'h1;
                end
            end
        end
    end

    // receiver: start qualified at mid-bit, then one sample per sixteen ticks
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            rx_state_r  <= RX_IDLE;
            rx_sub_r    <= 4'h0;
            rx_bit_r    <= 4'h0;
            rx_shift_r  <= 8'h00;
            rx_prev_r   <= 1'b1;
            rx_data     <= 8'h00;
            rx_valid    <= 1'b0;
            rx_stop_bit <= 1'b0;
        end else begin
            rx_prev_r <= rx_in;
            rx_valid  <= 1'b0;
            case (rx_state_r)
                RX_IDLE: begin
                    if (rx_prev_r && !rx_in) begin
                        rx_state_r <= RX_START;
                        rx_sub_r   <= 4'h0;
                    end
                end
                RX_START: begin
                    if (rx_tick) begin
                        rx_sub_r <= rx_sub_r + 4'h1;
                        if (rx_sub_r == `MID_SAMPLE) begin
                            // a glitch shorter than half a bit is dropped
                            rx_state_r <= rx_in ? RX_IDLE : RX_DATA;
                            rx_sub_r   <= 4'h0;
                            rx_bit_r   <= 4'h0;
                        end
                    end
                end
                RX_DATA: begin
                    if (rx_tick) begin
                        rx_sub_r <= rx_sub_r + 4'h1;
                        if (rx_sub_r == `OVERSAMPLE_LAST) begin
                            rx_shift_r <= {rx_in, rx_shift_r[7:1]};
                            rx_bit_r   <= rx_bit_r + 4'h1;
                            if (rx_bit_r == `LAST_DATA_INDEX)
                                rx_state_r <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_tick) begin
                        rx_sub_r <= rx_sub_r + 4'h1;
                        if (rx_sub_r == `OVERSAMPLE_LAST) begin
                            rx_stop_bit <= rx_in;
                            rx_data     <= rx_shift_r;
                            rx_valid    <= 1'b1;
                            rx_state_r  <= RX_IDLE;
                        end
                    end
                end
                default: rx_state_r <= RX_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### serial_mode1_properties.sv
/* port-level properties of the two serial ports and the 16-bit timer flag.
   assumes it is bound to serial_mode1_baud_gen and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module serial_mode1_checker (
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic       tx_clock_from_timer16,
    input wire logic       rx_clock_from_timer16,
    input wire logic       timer16_overflow_clear,
    input wire logic       timer16_overflow_flag,
    input wire logic       tx_start_port0,
    input wire logic       tx_busy_port0,
    input wire logic       txd_port0,
    input wire logic       rx_valid_port0,
    input wire logic [7:0] rx_data_port0,
    input wire logic       tx_start_port1,
    input wire logic       tx_busy_port1,
    input wire logic       txd_port1,
    input wire logic       rx_valid_port1
);
    // either serial select takes the 16-bit timer away from its flag
    wire logic serial_sel = tx_clock_from_timer16 | rx_clock_from_timer16;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // transmit lines: mark level outside frames, start bit on launch
    idle_high0_a: assert property (!tx_busy_port0 |-> txd_port0)
        else $error("port0 line low while idle");
    idle_high1_a: assert property (!tx_busy_port1 |-> txd_port1)
        else $error("port1 line low while idle");
    launch_start0_a: assert property (tx_start_port0 && !tx_busy_port0
        |=> tx_busy_port0 && !txd_port0) else $error("port0 no start bit");
    launch_start1_a: assert property (tx_start_port1 && !tx_busy_port1
        |=> tx_busy_port1 && !txd_port1) else $error("port1 no start bit");
    stop_before_end_a: assert property ($fell(tx_busy_port0)
        |-> $past(txd_port0)) else $error("port0 frame ended without stop");
    // receive side: one-cycle strobe, data held between frames
    rx_pulse_once_a: assert property (rx_valid_port0 |=> !rx_valid_port0)
        else $error("port0 valid longer than one cycle");
    rx_pulse_once1_a: assert property (rx_valid_port1 |=> !rx_valid_port1)
        else $error("port1 valid longer than one cycle");
    rx_data_hold_a: assert property (!rx_valid_port0
        |-> $stable(rx_data_port0)) else $error("port0 data moved");
    // flag stays quiet under serial use and is sticky otherwise
    flag_quiet_a: assert property (serial_sel && $past(serial_sel)
        && !timer16_overflow_flag |=> !timer16_overflow_flag)
        else $error("flag set while timer serves serial clock");
    flag_sticky_a: assert property (timer16_overflow_flag
        && !timer16_overflow_clear |=> timer16_overflow_flag)
        else $error("flag dropped without clear");
    cover property (rx_valid_port0);
    cover property (rx_valid_port1);
    cover property ($rose(timer16_overflow_flag));
endmodule
`default_nettype wire

// ### serial_partner.sv
/* behavioural far-end serial partner: sends frames on line_out and
   decodes frames seen on line_in. assumes the bench sets bit_cyc. */
`timescale 1ns/1ns
`default_nettype none
module serial_partner (
    input  wire logic ref_clk,
    input  wire logic line_in,
    output var logic  line_out
);
    int         bit_cyc  = 32;
    int         low_cyc  = 0;
    int         frames   = 0;
    int         i;
    logic [7:0] got      = 8'h00;
    logic       got_stop = 1'b0;
    logic       seen;
    initial line_out = 1'b1;
    // decode at bit centres reckoned from the falling start edge
    always begin
        @(negedge line_in);
        seen = 1'b0;
        for (i = 1; i <= 9 * bit_cyc + bit_cyc / 2; i++) begin
            @(posedge ref_clk);
            if (line_in && !seen) begin
                seen = 1'b1;
                low_cyc = i;
            end
            if (i % bit_cyc == bit_cyc / 2 && i > bit_cyc) begin
                if (i < 9 * bit_cyc) got[i / bit_cyc - 1] = line_in;
                else got_stop = line_in;
            end
        end
        frames++;
    end
    // stop is held a bit and a half so a late receiver still sees it
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] bits;
        int         j;
        bits = {stop, d, 1'b0};
        @(negedge ref_clk);
        for (j = 0; j < 10; j++) begin
            line_out = bits[j];
            repeat (j == 9 ? bit_cyc * 3 / 2 : bit_cyc) @(negedge ref_clk);
        end
        line_out = 1'b1;
    endtask
endmodule
`default_nettype wire

// ### tb_serial_mode1_baud_gen.sv
/* self-checking bench for the two serial ports and their baud timers.
   assumes a 10 MHz ref_clk and one partner model on each port. */
`timescale 1ns/1ns
`default_nettype none
module tb_serial_mode1_baud_gen;
    logic ref_clk = 1'b0, rst_n = 1'b0;
    logic [7:0] power_control_reg = 8'h00, ext_interrupt_control_reg = 8'h00;
    logic [7:0] timer8_reload_byte = 8'h00, timer16_reload_high = 8'h00;
    logic [7:0] timer16_reload_low = 8'h00;
    logic [7:0] tx_data_port0 = 8'h00, tx_data_port1 = 8'h00;
    logic timer8_run = 1'b0, timer16_run = 1'b0, timer16_clock_rate_sel = 1'b0;
    logic tx_clock_from_timer16 = 1'b0, rx_clock_from_timer16 = 1'b0;
    logic timer16_ext_reload_enable = 1'b0, timer16_ext_reload_trigger = 1'b1;
    logic timer16_overflow_clear = 1'b0;
    logic tx_start_port0 = 1'b0, tx_start_port1 = 1'b0;
    wire logic rxd_port0, rxd_port1, timer16_overflow_flag;
    wire logic tx_busy_port0, txd_port0, rx_valid_port0, rx_stop_bit_port0;
    wire logic tx_busy_port1, txd_port1, rx_valid_port1, rx_stop_bit_port1;
    wire logic [7:0] rx_data_port0, rx_data_port1;
    int fails = 0, total_checks = 0;
    always #50 ref_clk = ~ref_clk;
    serial_mode1_baud_gen dut (.ref_clk, .rst_n, .power_control_reg,
        .ext_interrupt_control_reg, .timer8_run, .timer8_reload_byte,
        .timer16_run, .timer16_reload_high, .timer16_reload_low,
        .tx_clock_from_timer16, .rx_clock_from_timer16,
        .timer16_clock_rate_sel, .timer16_ext_reload_enable,
        .timer16_ext_reload_trigger, .timer16_overflow_clear,
        .timer16_overflow_flag, .tx_data_port0, .tx_start_port0,
        .tx_busy_port0, .txd_port0, .rxd_port0, .rx_data_port0,
        .rx_valid_port0, .rx_stop_bit_port0, .tx_data_port1,
        .tx_start_port1, .tx_busy_port1, .txd_port1, .rxd_port1,
        .rx_data_port1, .rx_valid_port1, .rx_stop_bit_port1);
    serial_partner p0 (.ref_clk, .line_in(txd_port0), .line_out(rxd_port0));
    serial_partner p1 (.ref_clk, .line_in(txd_port1), .line_out(rxd_port1));
    task automatic check8(input logic [7:0] got, exp, input string what);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic check_rng(input int got, lo, hi, input string what);
        total_checks++;
        if (got < lo || got > hi) begin
            fails++;
            $display("[FAIL] %0t %s %0d not in %0d..%0d", $time, what, got, lo, hi);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // one-cycle start request on either port
    task automatic tx_go(input int port, input logic [7:0] d);
        @(negedge ref_clk);
        if (port == 0) begin
            tx_data_port0 = d;
            tx_start_port0 = 1'b1;
        end else begin
            tx_data_port1 = d;
            tx_start_port1 = 1'b1;
        end
        @(negedge ref_clk);
        if (port == 0) tx_start_port0 = 1'b0;
        else tx_start_port1 = 1'b0;
    endtask
    task automatic clear_then_wait(output int n);
        timer16_overflow_clear = 1'b1;
        wait_n(1);
        timer16_overflow_clear = 1'b0;
        for (n = 0; timer16_overflow_flag !== 1'b1 && n < 500; n++) wait_n(1);
    endtask
    // cycles per bit on the 8-bit timer, 32 * 12 core cycles per count, 16 * 12 with dbl
    function automatic int bit_len(input logic [7:0] rl, input logic dbl);
        return 384 * (256 - rl) / (dbl ? 2 : 1);
    endfunction
    // trigger loads the 16-bit timer; flag period at /4 then /12
    task t_flag;
        int n;
        int r;
        timer16_reload_high = 8'hFF;
        timer16_reload_low = 8'hF0;
        timer16_ext_reload_enable = 1'b1;
        timer16_run = 1'b1;
        timer16_ext_reload_trigger = 1'b0;
        wait_n(4);
        timer16_ext_reload_trigger = 1'b1;
        for (r = 0; r < 2; r++) begin
            timer16_clock_rate_sel = (r == 0);
            clear_then_wait(n);
            clear_then_wait(n);
            check_rng(n, (r ? 192 : 64) - 4, (r ? 192 : 64) + 1, "period");
        end
        tx_clock_from_timer16 = 1'b1;
        clear_then_wait(n);
        check8({7'h00, timer16_overflow_flag}, 8'h00, "flag quiet");
        $display("test flag done");
    endtask
    // port 0 on the 16-bit timer, both directions, one start refused
    task t_link16;
        int f0;
        timer16_reload_low = 8'hFE;
        rx_clock_from_timer16 = 1'b1;
        p0.bit_cyc = 64;
        wait_n(100);
        f0 = p0.frames;
        fork
            begin
                tx_go(0, 8'hA5);
                wait_n(10);
                tx_go(0, 8'h00);
            end
            p0.send(8'h3C, 1'b1);
        join
        wait_n(100);
        check8(p0.got, 8'hA5, "tx byte");
        check8({7'h00, p0.got_stop}, 8'h01, "tx stop");
        check_rng(p0.low_cyc, 60, 66, "bit time");
        check_rng(p0.frames - f0, 1, 1, "frames");
        check8(rx_data_port0, 8'h3C, "rx byte");
        check8({7'h00, rx_stop_bit_port0}, 8'h01, "rx stop");
        p0.send(8'h81, 1'b0);
        wait_n(100);
        check8(rx_data_port0, 8'h81, "rx resync");
        check8({7'h00, rx_stop_bit_port0}, 8'h00, "rx stop low");
        $display("test link16 done");
    endtask
    // both ports transmit on the 8-bit timer with their own double-rate bits
    task t_rates(input logic [7:0] pc, ec, rl, input logic sel);
        int b0;
        int b1;
        b0 = bit_len(rl, pc[7]);
        b1 = bit_len(rl, ec[7]);
        tx_clock_from_timer16 = 1'b0;
        rx_clock_from_timer16 = sel;
        power_control_reg = pc;
        ext_interrupt_control_reg = ec;
        timer8_reload_byte = rl;
        timer8_run = 1'b1;
        p0.bit_cyc = b0;
        p1.bit_cyc = b1;
        wait_n(3200);
        fork
            tx_go(0, 8'hA5);
            tx_go(1, 8'hC3);
            p1.send(8'h96, 1'b1);
        join
        wait_n(11 * b0);
        check8(p0.got, 8'hA5, "port0 byte");
        check8(p1.got, 8'hC3, "port1 byte");
        check_rng(p0.low_cyc, b0 - b0 / 16, b0 + 2, "port0 bit");
        check_rng(p1.low_cyc, b1 - b1 / 16, b1 + 2, "port1 bit");
        check8(rx_data_port1, 8'h96, "port1 rx");
        check8({7'h00, rx_stop_bit_port1}, 8'h01, "port1 stop");
        $display("test rates done");
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // main sequence after twelve cycles of reset
    initial begin
        wait_n(12);
        rst_n = 1'b1;
        t_flag;
        t_link16;
        t_rates(8'h7F, 8'h80, 8'hFF, 1'b0);
        t_rates(8'h80, 8'h7F, 8'hFE, 1'b1);
        report_and_stop;
    end
    // watchdog well past the longest expected run
    initial begin
        repeat (60000) @(posedge ref_clk);
        fails++;
        report_and_stop;
    end
endmodule
bind serial_mode1_baud_gen serial_mode1_checker chk (.ref_clk, .rst_n,
    .tx_clock_from_timer16, .rx_clock_from_timer16, .timer16_overflow_clear,
    .timer16_overflow_flag, .tx_start_port0, .tx_busy_port0, .txd_port0,
    .rx_valid_port0, .rx_data_port0, .tx_start_port1, .tx_busy_port1,
    .txd_port1, .rx_valid_port1);
`default_nettype wire
